// File: pulse_reference_pkg.sv
// constants for the pulse reference decoder: register map, field layout,
// reset values and code points of the configuration fields.
// assumes a 16-bit register port with a 4-bit word address.
package pulse_reference_pkg;

	// register word addresses
	localparam logic [3:0]  ADDR_CFG          = 4'h0;
	localparam logic [3:0]  ADDR_LIMIT        = 4'h1;
	localparam logic [3:0]  ADDR_CFG_ACTIVE   = 4'h2;
	localparam logic [3:0]  ADDR_LIMIT_ACTIVE = 4'h3;
	localparam logic [3:0]  ADDR_DEV_LO       = 4'h4;
	localparam logic [3:0]  ADDR_DEV_HI       = 4'h5;

	// reset values
	localparam logic [15:0] CFG_RESET   = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'hffff;
	localparam logic [31:0] DEV_RESET   = 32'h0000_0000;

	// nibble positions inside pulse_input_configuration
	localparam int          POS_FORM   = 0;
	localparam int          POS_CLEAR  = 4;
	localparam int          POS_OP     = 8;
	localparam int          POS_FILTER = 12;

	// pulse form codes
	localparam logic [3:0]  FORM_SIGN_POS = 4'h0;
	localparam logic [3:0]  FORM_CWCCW_POS = 4'h1;
	localparam logic [3:0]  FORM_QUAD_X1  = 4'h2;
	localparam logic [3:0]  FORM_QUAD_X2  = 4'h3;
	localparam logic [3:0]  FORM_QUAD_X4  = 4'h4;
	localparam logic [3:0]  FORM_SIGN_NEG = 4'h5;
	localparam logic [3:0]  FORM_CWCCW_NEG = 4'h6;

	// clear signal form codes
	localparam logic [3:0]  CLR_HIGH    = 4'h0;
	localparam logic [3:0]  CLR_RISE    = 4'h1;
	localparam logic [3:0]  CLR_LOW     = 4'h2;
	localparam logic [3:0]  CLR_FALL    = 4'h3;

	// clear operation codes
	localparam logic [3:0]  OP_BASEBLOCK = 4'h0;
	localparam logic [3:0]  OP_NONE      = 4'h1;
	localparam logic [3:0]  OP_ALARM     = 4'h2;

	// number of filtered pins: phase a, phase b, clear
	localparam int          NUM_PINS = 3;

endpackage : pulse_reference_pkg

// File: pin_filter.sv
// three-stage input synchroniser with agreement filter for one pin.
// assumes the pin is asynchronous to clk; output changes only when the
// second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_filter (
	// clock, reset, enable
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	// raw pin and filtered level
	input  wire logic pin,
	output logic      level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} filt_t;

	filt_t cur;
	filt_t next_cur;

	// shift the pin in; s1 feeds only s2
	always_comb begin
		next_cur = cur;
		if (ce) begin
			next_cur.s1 = pin;
			next_cur.s2 = cur.s1;
			next_cur.s3 = cur.s2;
			if (cur.s2 == cur.s3) begin
				next_cur.level = cur.s3;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign level = cur.level;

endmodule : pin_filter
`default_nettype wire

// File: pulse_reference_decoder.sv
// pulse reference decoder: turns a reference pulse train into position
// increments and keeps the position deviation counter.
// assumes servo_on, alarm, restart and feedback come from clk-domain logic;
// pulse and clear pins are asynchronous and are filtered here.
//
// Function
// - quadrature x1: one count per full cycle, phase order sets direction
// - quadrature x2: two counts per cycle, direction from phase relation
// - quadrature x4: count every edge of both phases
// - clear form 0: deviation held at zero while clear input is high
// - operation 0: zero deviation while power stage blocked (servo off/alarm)
// - operation 1: keep deviation, cleared only by the clear input
// - operation 2: zero deviation on alarm only, not on servo off
// - multiturn limit 0..65535, default 65535, applied only after restart
`timescale 1ns/1ps
`default_nettype none
module pulse_reference_decoder (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// reference pins from the host controller
	input  wire logic        pulse_a,
	input  wire logic        pulse_b,
	input  wire logic        deviation_clear_input,
	// drive status and feedback
	input  wire logic        servo_on,
	input  wire logic        alarm,
	input  wire logic        restart,
	input  wire logic        fb_pulse,
	input  wire logic        fb_dir,
	// decoded outputs
	output logic             ref_inc_pulse,
	output logic             ref_inc_dir,
	output logic      [31:0] position_deviation,
	output logic      [15:0] revolution_limit
);

	typedef struct packed {
		logic [15:0] cfg_w;   // written configuration
		logic [15:0] lim_w;   // written limit
		logic [15:0] cfg;     // active configuration
		logic [15:0] lim;     // active limit
		logic        prev_a;
		logic        prev_b;
		logic        prev_clr;
		logic [31:0] dev;
		logic        inc_pulse;
		logic        inc_dir;
		logic [15:0] rdata;
	} state_t;

	state_t cur;
	state_t next_cur;

	// nibble extract, used for the form, clear form and clear operation fields
	function automatic logic [3:0] field(input logic [15:0] v,
		input int pos);
		field = v[pos +: 4];
	endfunction : field

	// filtered pins
	logic [pulse_reference_pkg::NUM_PINS-1:0] pin_raw;
	logic [pulse_reference_pkg::NUM_PINS-1:0] pin_lvl;
	assign pin_raw = {deviation_clear_input, pulse_b, pulse_a};

	genvar gi;
	generate
		for (gi = 0; gi < pulse_reference_pkg::NUM_PINS; gi++) begin : g_pin
			pin_filter u_filt (
				.clk   (clk),
				.rstn  (rstn),
				.ce    (ce),
				.pin   (pin_raw[gi]),
				.level (pin_lvl[gi])
			);
		end
	endgenerate

	// configuration fields
	logic [3:0] form;
	logic [3:0] clr_form;
	logic [3:0] clr_op;
	assign form     = field(cur.cfg, pulse_reference_pkg::POS_FORM);
	assign clr_form = field(cur.cfg, pulse_reference_pkg::POS_CLEAR);
	assign clr_op   = field(cur.cfg, pulse_reference_pkg::POS_OP);

	// polarity: negative logic forms invert both phases
	logic neg;
	logic pa;
	logic pb;
	logic pclr;
	assign neg  = (form == pulse_reference_pkg::FORM_SIGN_NEG) ||
		(form == pulse_reference_pkg::FORM_CWCCW_NEG);
	assign pa   = pin_lvl[0] ^ neg;
	assign pb   = pin_lvl[1] ^ neg;
	assign pclr = pin_lvl[2];

	// edge terms
	logic a_rise;
	logic b_rise;
	logic a_chg;
	logic b_chg;
	assign a_rise = pa && !cur.prev_a;
	assign b_rise = pb && !cur.prev_b;
	assign a_chg  = pa != cur.prev_a;
	assign b_chg  = pb != cur.prev_b;

	// increment decode by pulse form
	logic inc_now;
	logic inc_fwd;
	always_comb begin
		inc_now = 1'b0;
		inc_fwd = 1'b0;
		case (form)
			pulse_reference_pkg::FORM_SIGN_POS,
			pulse_reference_pkg::FORM_SIGN_NEG: begin
				inc_now = a_rise;
				inc_fwd = !pb;                           // sign low: forward
			end
			pulse_reference_pkg::FORM_CWCCW_POS,
			pulse_reference_pkg::FORM_CWCCW_NEG: begin
				inc_now = a_rise ^ b_rise;
				inc_fwd = a_rise;
			end
			pulse_reference_pkg::FORM_QUAD_X1: begin
				inc_now = a_rise && !b_chg;
				inc_fwd = !pb;                           // a leads b
			end
			pulse_reference_pkg::FORM_QUAD_X2: begin
				inc_now = a_chg && !b_chg;
				inc_fwd = pa ^ pb;
			end
			pulse_reference_pkg::FORM_QUAD_X4: begin
				inc_now = a_chg ^ b_chg;
				inc_fwd = cur.prev_a == pb;
			end
			default: begin
				inc_now = 1'b0;                          // unused codes
				inc_fwd = 1'b0;
			end
		endcase
	end

	// clear request from the clear input
	logic clr_pin;
	always_comb begin
		case (clr_form)
			pulse_reference_pkg::CLR_HIGH: clr_pin = pclr;
			pulse_reference_pkg::CLR_RISE: clr_pin = pclr && !cur.prev_clr;
			pulse_reference_pkg::CLR_LOW:  clr_pin = !pclr;
			pulse_reference_pkg::CLR_FALL: clr_pin = !pclr && cur.prev_clr;
			default:                       clr_pin = 1'b0;
		endcase
	end

	// clear request from drive status
	logic clr_stat;
	always_comb begin
		case (clr_op)
			pulse_reference_pkg::OP_BASEBLOCK: clr_stat = !servo_on || alarm;
			pulse_reference_pkg::OP_ALARM:     clr_stat = alarm;
			default:                           clr_stat = 1'b0;
		endcase
	end

	logic clr_req;
	assign clr_req = clr_pin || clr_stat;

	// net deviation step: reference adds, feedback subtracts
	logic [31:0] dev_step;
	always_comb begin
		dev_step = cur.dev;
		if (inc_now) begin
			dev_step = inc_fwd ? dev_step + 32'h0000_0001 :
				dev_step - 32'h0000_0001;
		end
		if (fb_pulse) begin
			dev_step = fb_dir ? dev_step - 32'h0000_0001 :
				dev_step + 32'h0000_0001;
		end
	end

	// next state
	always_comb begin
		next_cur = cur;
		if (ce) begin
			next_cur.prev_a    = pa;
			next_cur.prev_b    = pb;
			next_cur.prev_clr  = pclr;
			next_cur.inc_pulse = inc_now;
			next_cur.inc_dir   = inc_fwd;
			next_cur.dev       = clr_req ? pulse_reference_pkg::DEV_RESET :
				dev_step;
			// register writes land in the shadow copies
			if (wr) begin
				case (addr)
					pulse_reference_pkg::ADDR_CFG:   next_cur.cfg_w = wdata;
					pulse_reference_pkg::ADDR_LIMIT: next_cur.lim_w = wdata;
					default: ;
				endcase
			end
			// shadow copies take effect only at restart
			if (restart) begin
				next_cur.cfg = cur.cfg_w;
				next_cur.lim = cur.lim_w;
			end
			// read data stands in the cycle after the strobe only
			next_cur.rdata = 16'h0000;
			if (rd) begin
				case (addr)
					pulse_reference_pkg::ADDR_CFG:
						next_cur.rdata = cur.cfg_w;
					pulse_reference_pkg::ADDR_LIMIT:
						next_cur.rdata = cur.lim_w;
					pulse_reference_pkg::ADDR_CFG_ACTIVE:
						next_cur.rdata = cur.cfg;
					pulse_reference_pkg::ADDR_LIMIT_ACTIVE:
						next_cur.rdata = cur.lim;
					pulse_reference_pkg::ADDR_DEV_LO:
						next_cur.rdata = cur.dev[15:0];
					pulse_reference_pkg::ADDR_DEV_HI:
						next_cur.rdata = cur.dev[31:16];
					default:
						next_cur.rdata = 16'h0000;
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur       <= '0;
			cur.cfg_w <= pulse_reference_pkg::CFG_RESET;
			cur.cfg   <= pulse_reference_pkg::CFG_RESET;
			cur.lim_w <= pulse_reference_pkg::LIMIT_RESET;
			cur.lim   <= pulse_reference_pkg::LIMIT_RESET;
			cur.dev   <= pulse_reference_pkg::DEV_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from flops
	assign rdata              = cur.rdata;
	assign ref_inc_pulse      = cur.inc_pulse;
	assign ref_inc_dir        = cur.inc_dir;
	assign position_deviation = cur.dev;
	assign revolution_limit   = cur.lim;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_quad_x1;
		(ce && form == pulse_reference_pkg::FORM_QUAD_X1 && a_rise && !b_chg)
		|=> ref_inc_pulse && (ref_inc_dir == !$past(pb));
	endproperty
	a_quad_x1: assert property (p_quad_x1)
		else $error("x1 quadrature edge not counted");

	property p_quad_x2;
		(ce && form == pulse_reference_pkg::FORM_QUAD_X2 && a_chg && !b_chg)
		|=> ref_inc_pulse && (ref_inc_dir == ($past(pa) ^ $past(pb)));
	endproperty
	a_quad_x2: assert property (p_quad_x2)
		else $error("x2 quadrature edge not counted");

	property p_quad_x4;
		(ce && form == pulse_reference_pkg::FORM_QUAD_X4 && (a_chg ^ b_chg))
		|=> ref_inc_pulse;
	endproperty
	a_quad_x4: assert property (p_quad_x4)
		else $error("x4 quadrature edge not counted");

	property p_sign;
		(ce && form == pulse_reference_pkg::FORM_SIGN_NEG && a_rise)
		|=> ref_inc_pulse && (ref_inc_dir == !$past(pb));
	endproperty
	a_sign: assert property (p_sign)
		else $error("sign and pulse edge not counted");

	property p_clr_high;
		(ce && clr_form == pulse_reference_pkg::CLR_HIGH && pclr)
		|=> position_deviation == 32'h0000_0000;
	endproperty
	a_clr_high: assert property (p_clr_high)
		else $error("deviation not held at zero by clear input");

	property p_clr_fall;
		(ce && clr_form == pulse_reference_pkg::CLR_FALL && !pclr &&
			cur.prev_clr) |=> position_deviation == 32'h0000_0000;
	endproperty
	a_clr_fall: assert property (p_clr_fall)
		else $error("falling clear edge did not zero deviation");

	property p_baseblock;
		(ce && clr_op == pulse_reference_pkg::OP_BASEBLOCK && !servo_on)
		|=> position_deviation == 32'h0000_0000;
	endproperty
	a_baseblock: assert property (p_baseblock)
		else $error("deviation not zeroed at servo off");

	property p_keep;
		(ce && clr_op == pulse_reference_pkg::OP_NONE && !clr_pin &&
			!inc_now && !fb_pulse) |=> $stable(position_deviation);
	endproperty
	a_keep: assert property (p_keep)
		else $error("deviation changed without cause");

	property p_alarm;
		(ce && clr_op == pulse_reference_pkg::OP_ALARM && alarm)
		|=> position_deviation == 32'h0000_0000;
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("deviation not zeroed on alarm");

	property p_limit;
		!(ce && restart) |=> $stable(revolution_limit);
	endproperty
	a_limit: assert property (p_limit)
		else $error("limit changed without restart");

endmodule : pulse_reference_decoder
`default_nettype wire

// File: host_pulse_source.sv
// host motion controller model: drives the reference pulse pins.
// assumes tasks are called from the bench; pins change after rising edges.
`timescale 1ns/1ps
`default_nettype none
module host_pulse_source (
	// clock
	input  wire logic clk,
	// reference pins
	output var logic  pulse_a,
	output var logic  pulse_b
);
	logic [3:0] form;
	logic       inv;

	// idle pins and positive logic at start
	initial begin
		form = 4'h0;
		inv = 1'b0;
		pulse_a = 1'b0;
		pulse_b = 1'b0;
	end

	// hold each level four cycles so the filter sees it
	task automatic put(input logic a, input logic b);
		repeat (4) @(posedge clk);
		pulse_a <= a ^ inv;
		pulse_b <= b ^ inv;
	endtask : put

	// select a form and park the pins at its idle level
	task automatic set_form(input logic [3:0] f);
		form = f;
		inv = (f == pulse_reference_pkg::FORM_SIGN_NEG) ||
			(f == pulse_reference_pkg::FORM_CWCCW_NEG);
		put(1'b0, 1'b0);
	endtask : set_form

	// one reference step in the current form
	task automatic step(input logic fwd);
		case (form)
			pulse_reference_pkg::FORM_QUAD_X1,
			pulse_reference_pkg::FORM_QUAD_X2,
			pulse_reference_pkg::FORM_QUAD_X4: begin
				// a leads b when moving forward
				if (fwd) begin
					put(1, 0); put(1, 1); put(0, 1); put(0, 0);
				end else begin
					put(0, 1); put(1, 1); put(1, 0); put(0, 0);
				end
			end
			pulse_reference_pkg::FORM_CWCCW_POS,
			pulse_reference_pkg::FORM_CWCCW_NEG: begin
				put(fwd, !fwd);
				put(0, 0);
			end
			default: begin
				// sign settles before the pulse edge
				put(0, !fwd); put(1, !fwd); put(0, !fwd);
			end
		endcase
	endtask : step
endmodule : host_pulse_source
`default_nettype wire

// File: testbench.sv
// self-checking bench for the pulse reference decoder.
// assumes the host model drives the pulse pins; bench owns all else.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, rstn, ce, wr, rd, clr;
	logic        servo_on, alarm, restart, fb_pulse, fb_dir;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, revolution_limit, v;
	logic        pulse_a, pulse_b, ref_inc_pulse, ref_inc_dir;
	logic [31:0] position_deviation;
	int          num_errors, tests_run, seed, exp_dev, n, f, inc_sum, base;

	// 10 mhz clock
	always #50 clk = ~clk;

	// net signed count of increments seen on the decoded outputs
	always @(posedge clk) begin
		if (ref_inc_pulse) begin
			inc_sum <= ref_inc_dir ? inc_sum + 1 : inc_sum - 1;
		end
	end

	pulse_reference_decoder i_pulse_reference_decoder (.clk(clk),
		.rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .pulse_a(pulse_a), .pulse_b(pulse_b),
		.deviation_clear_input(clr), .servo_on(servo_on), .alarm(alarm),
		.restart(restart), .fb_pulse(fb_pulse), .fb_dir(fb_dir),
		.ref_inc_pulse(ref_inc_pulse), .ref_inc_dir(ref_inc_dir),
		.position_deviation(position_deviation),
		.revolution_limit(revolution_limit));
	host_pulse_source i_host_pulse_source (.clk(clk), .pulse_a(pulse_a),
		.pulse_b(pulse_b));

	// verdict and end of run
	task automatic finish_test;
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// one comparison
	task automatic check(input string nm, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// register write, one cycle strobe
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// register read, data sampled in the following cycle
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check("rdata", {16'h0000, rdata}, {16'h0000, e});
	endtask : rd_chk

	// write config, restart, let pins settle
	task automatic cfg(input logic [3:0] fm, cf, op);
		wr_reg(pulse_reference_pkg::ADDR_CFG, {4'h0, op, cf, fm});
		@(posedge clk) restart <= 1'b1;
		@(posedge clk) restart <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : cfg

	// pulse the clear pin away from its idle level
	task automatic clr_pulse(input logic idle);
		@(posedge clk) clr <= !idle;
		repeat (6) @(posedge clk);
		clr <= idle;
		repeat (8) @(posedge clk);
		exp_dev = 0;
	endtask : clr_pulse

	// compare deviation with the model after the pipeline drains
	task automatic dev_chk;
		repeat (8) @(posedge clk);
		#1 check("deviation", position_deviation, exp_dev);
	endtask : dev_chk

	// increments per step of a form
	function automatic int per(input logic [3:0] fm);
		if (fm == pulse_reference_pkg::FORM_QUAD_X2) return 2;
		if (fm == pulse_reference_pkg::FORM_QUAD_X4) return 4;
		return 1;
	endfunction : per

	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		finish_test();
	end

	// main sequence
	initial begin
		clk = 0; rstn = 0; ce = 1; wr = 0; rd = 0; clr = 0; addr = 0;
		wdata = 0; servo_on = 1; alarm = 0; restart = 0; fb_pulse = 0;
		fb_dir = 0; num_errors = 0; tests_run = 0; seed = 8; exp_dev = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// reset values, unmapped read, limit applied on restart only
		rd_chk(pulse_reference_pkg::ADDR_CFG, 16'h0000);
		rd_chk(pulse_reference_pkg::ADDR_LIMIT, 16'hffff);
		rd_chk(4'hf, 16'h0000);
		v = 16'($random(seed));
		wr_reg(pulse_reference_pkg::ADDR_LIMIT, v);
		rd_chk(pulse_reference_pkg::ADDR_LIMIT, v);
		check("limit", {16'h0, revolution_limit}, 32'h0000ffff);
		cfg(4'h0, 4'h0, 4'h1);
		check("limit", {16'h0, revolution_limit}, {16'h0, v});
		rd_chk(pulse_reference_pkg::ADDR_LIMIT_ACTIVE, v);
		// every pulse form, random forward run then one reverse step
		for (f = 0; f < 7; f++) begin
			i_host_pulse_source.set_form(f[3:0]);
			cfg(f[3:0], 4'h0, 4'h1);
			clr_pulse(1'b0);
			base = inc_sum;
			n = 2 + $unsigned($random(seed)) % 3;
			repeat (n) i_host_pulse_source.step(1'b1);
			i_host_pulse_source.step(1'b0);
			exp_dev = per(f[3:0]) * (n - 1);
			dev_chk();
			check("increments", inc_sum - base, exp_dev);
		end
		// feedback steps: five forward then one backward
		@(posedge clk) begin fb_pulse <= 1'b1; fb_dir <= 1'b1; end
		repeat (5) @(posedge clk);
		fb_dir <= 1'b0;
		@(posedge clk) fb_pulse <= 1'b0;
		exp_dev = exp_dev - 4;
		dev_chk();
		// clock enable low freezes the deviation against feedback
		@(posedge clk) begin ce <= 1'b0; fb_pulse <= 1'b1; end
		repeat (3) @(posedge clk);
		@(posedge clk) begin ce <= 1'b1; fb_pulse <= 1'b0; end
		dev_chk();
		rd_chk(pulse_reference_pkg::ADDR_DEV_LO, exp_dev[15:0]);
		rd_chk(pulse_reference_pkg::ADDR_DEV_HI, exp_dev[31:16]);
		rd_chk(pulse_reference_pkg::ADDR_CFG_ACTIVE, 16'h0106);
		// reset in mid-run restores defaults and zeroes the deviation
		@(posedge clk) rstn <= 1'b0;
		#1 check("deviation", position_deviation, 32'h0000_0000);
		check("limit", {16'h0, revolution_limit}, 32'h0000ffff);
		@(posedge clk) rstn <= 1'b1;
		rd_chk(pulse_reference_pkg::ADDR_CFG_ACTIVE, 16'h0000);
		// every clear signal form
		i_host_pulse_source.set_form(pulse_reference_pkg::FORM_QUAD_X4);
		for (f = 0; f < 4; f++) begin
			@(posedge clk) clr <= (f == 2);
			cfg(pulse_reference_pkg::FORM_QUAD_X4, f[3:0], 4'h1);
			clr_pulse(f == 2);
			i_host_pulse_source.step(1'b1);
			exp_dev = 4;
			dev_chk();
			clr_pulse(f == 2);
			dev_chk();
		end
		// every clear operation against servo off and alarm
		for (f = 0; f < 3; f++) begin
			cfg(pulse_reference_pkg::FORM_QUAD_X4, 4'h0, f[3:0]);
			clr_pulse(1'b0);
			i_host_pulse_source.step(1'b1);
			exp_dev = 4;
			dev_chk();
			@(posedge clk) servo_on <= 1'b0;
			if (f == 0) exp_dev = 0;
			dev_chk();
			@(posedge clk) begin servo_on <= 1'b1; alarm <= 1'b1; end
			if (f != 1) exp_dev = 0;
			dev_chk();
			@(posedge clk) alarm <= 1'b0;
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
